// File: shared/fpfmt_consts.vh
// constants for the floating-point operand format unit
`ifndef FPFMT_CONSTS_VH
`define FPFMT_CONSTS_VH

// operation codes on op_code
`define FPFMT_OP_UNPACK 2'h0
`define FPFMT_OP_PACK 2'h1
`define FPFMT_OP_I2F 2'h2
`define FPFMT_OP_F2I 2'h3

// packed 64-bit operand layout, first memory word in bits 63:48
`define FPFMT_SIGN_BIT 63
`define FPFMT_EXP_MSB 62
`define FPFMT_EXP_LSB 55
`define FPFMT_FRAC_MSB 54
`define FPFMT_SFRAC_LSB 32
`define FPFMT_DFRAC_LSB 0

// significand with hidden bit: 56 bits, hidden one at bit 55
`define FPFMT_HIDDEN_BIT 55
`define FPFMT_SINGLE_SIG_LSB 32

// exponent bias (200 octal) and true exponent limits, 10-bit two's complement
`define FPFMT_EXP_BIAS 10'h080
`define FPFMT_EXP_MAX 10'h07F
`define FPFMT_EXP_MIN 10'h381

// significand width as shift base, and integer magnitude limits
`define FPFMT_SIG_WIDTH 7'h38
`define FPFMT_LONG_BITS 10'h020
`define FPFMT_LONG_LIMIT 56'h00000080000000
`define FPFMT_SHORT_LIMIT 56'h00000000008000

// reset value of the result_word register
`define FPFMT_RESET_WORD 64'h0000000000000000

`endif

// File: verilog/fpfmt_unpack.v
// combinational unpack of a packed floating operand
`timescale 1ns/10ps
`default_nettype none
`include "fpfmt_consts.vh"

module fpfmt_unpack (
  input wire [63:0] operand,
  input wire double_mode,
  output wire sign,
  output wire [9:0] true_exp,
  output wire [55:0] significand,
  output wire is_zero,
  output wire is_dirty,
  output wire is_undefined
);

  wire [7:0] biased; // stored exponent field
  wire [54:0] frac; // stored fraction, single mode low part masked

  // one means negative
  assign sign = operand[`FPFMT_SIGN_BIT];
  assign biased = operand[`FPFMT_EXP_MSB:`FPFMT_EXP_LSB];
  // single mode keeps 23 fraction bits, double mode 55
  assign frac = double_mode ? operand[`FPFMT_FRAC_MSB:`FPFMT_DFRAC_LSB] :
    {operand[`FPFMT_FRAC_MSB:`FPFMT_SFRAC_LSB], 32'h00000000};
  // biased exponent zero is floating zero, whatever the fraction
  assign is_zero = (biased == 8'h00);
  assign is_dirty = is_zero && (frac != 55'h0);
  assign is_undefined = is_zero && sign;
  // remove the bias
  assign true_exp = {2'h0, biased} - `FPFMT_EXP_BIAS;
  // reinsert the hidden one; zero operands become an exact zero
  assign significand = is_zero ? 56'h0 : {1'b1, frac};

endmodule
`default_nettype wire

// File: verilog/fpfmt_unit.v
// floating operand format unit: unpack, pack and integer conversion
`timescale 1ns/10ps
`default_nettype none
`include "fpfmt_consts.vh"

module fpfmt_unit (
  input wire clock,
  input wire nrst,
  input wire enable,
  input wire start,
  input wire [1:0] op_code,
  input wire double_mode,
  input wire long_mode,
  input wire check_undefined,
  input wire undefined_operand_interrupt_enable,
  input wire overflow_interrupt_enable,
  input wire underflow_interrupt_enable,
  input wire [63:0] operand,
  input wire pack_sign,
  input wire [9:0] pack_exp,
  input wire [55:0] pack_significand,
  input wire [31:0] int_operand,
  output reg done,
  output reg [63:0] result_word,
  output reg result_sign,
  output reg [9:0] result_exp,
  output reg [55:0] result_significand,
  output reg [31:0] result_integer,
  output reg flag_zero,
  output reg flag_dirty_zero,
  output reg flag_undefined,
  output reg flag_overflow,
  output reg flag_underflow,
  output reg flag_convert_fail,
  output reg undefined_trap,
  output reg overflow_trap,
  output reg underflow_trap
);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // position of the leading one of a 32-bit magnitude
  // the last set bit found wins, so the highest one is reported
  // a zero magnitude reports position zero; the caller relies on the zero significand that follows
  function [4:0] fpfmt_lead;
    input [31:0] value;
    integer i;
    begin
      fpfmt_lead = 5'h00;
      for (i = 0; i < 32; i = i + 1) begin
        if (value[i]) begin
          fpfmt_lead = i[4:0];
        end
      end
    end
  endfunction

  // pack sign, true exponent and significand: {overflow, underflow, word}
  // the range test works on the true exponent, before the biased field wraps
  // an exact zero significand wins over both exponent flags
  function [65:0] fpfmt_pack;
    input sgn;
    input [9:0] texp;
    input [55:0] sig;
    input dbl;
    input ovf_ie;
    input unf_ie;
    reg [9:0] biased;
    reg ovf;
    reg unf;
    reg [63:0] word;
    begin
      biased = texp + `FPFMT_EXP_BIAS;
      // signed range check on the true exponent
      ovf = !texp[9] && (texp > `FPFMT_EXP_MAX);
      unf = texp[9] && (texp < `FPFMT_EXP_MIN);
      // drop the hidden bit; single mode clears the second half
      if (dbl) begin
        word = {sgn, biased[7:0], sig[`FPFMT_HIDDEN_BIT-1:0]};
      end else begin
        word = {sgn, biased[7:0], sig[`FPFMT_HIDDEN_BIT-1:`FPFMT_SINGLE_SIG_LSB],
          32'h00000000};
      end
      if (sig == 56'h0) begin
        // exact zero: every bit clear, no exception
        word = `FPFMT_RESET_WORD;
        ovf = 1'b0;
        unf = 1'b0;
      end else if ((ovf && !ovf_ie) || (unf && !unf_ie)) begin
        // disabled exception never leaves a minus zero behind
        word = `FPFMT_RESET_WORD;
      end
      fpfmt_pack = {ovf, unf, word};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // operand unpack

  // one unpacker serves both the unpack and the float-to-integer paths
  wire up_sign; // sign of the memory operand
  wire [9:0] up_exp; // true exponent of the memory operand
  wire [55:0] up_sig; // significand with hidden bit
  wire up_zero; // biased exponent zero
  wire up_dirty; // zero with fraction bits set
  wire up_undef; // minus zero

  fpfmt_unpack u_unpack (
    .operand(operand),
    .double_mode(double_mode),
    .sign(up_sign),
    .true_exp(up_exp),
    .significand(up_sig),
    .is_zero(up_zero),
    .is_dirty(up_dirty),
    .is_undefined(up_undef)
  );

  ////////////////////////////////////////////////////////////////////////////
  // integer to floating

  reg [31:0] i2f_value; // integer, short form sign-extended
  reg [31:0] i2f_mag; // magnitude of the integer
  reg [4:0] i2f_lead; // leading one position
  reg [55:0] i2f_sig; // normalised significand
  reg [9:0] i2f_exp; // true exponent
  reg [65:0] i2f_packed; // packed result with flags

  // normalise the two's complement integer, low bits chopped in single mode
  // the shift puts the leading one on the hidden bit position
  // a 32-bit integer never leaves the exponent range, so no flags arise
  always @* begin
    i2f_value = long_mode ? int_operand :
      {{16{int_operand[15]}}, int_operand[15:0]};
    i2f_mag = i2f_value[31] ? (32'h00000000 - i2f_value) : i2f_value;
    i2f_lead = fpfmt_lead(i2f_mag);
    i2f_sig = {i2f_mag, 24'h000000} << (5'h1F - i2f_lead);
    i2f_exp = {5'h00, i2f_lead} + 10'h001;
    i2f_packed = fpfmt_pack(i2f_value[31], i2f_exp, i2f_sig, double_mode,
      overflow_interrupt_enable, underflow_interrupt_enable);
  end

  ////////////////////////////////////////////////////////////////////////////
  // floating to integer

  reg [6:0] f2i_shift; // right shift that leaves the integer part
  reg [55:0] f2i_mag; // integer magnitude
  reg [55:0] f2i_limit; // largest magnitude, reached only when negative
  reg f2i_fail; // conversion failure
  reg [31:0] f2i_value; // two's complement integer

  // chop the fraction and check the range of the chosen integer size
  // only a negative value may reach the limit magnitude
  // exponents above 32 fail before the shift, so the shift stays in range
  always @* begin
    f2i_shift = 7'h00;
    f2i_mag = 56'h0;
    f2i_fail = 1'b0;
    f2i_limit = long_mode ? `FPFMT_LONG_LIMIT : `FPFMT_SHORT_LIMIT;
    if (up_zero || up_exp[9] || (up_exp == 10'h000)) begin
      // zero, dirty zero or pure fraction gives zero
      f2i_mag = 56'h0;
    end else if (up_exp > `FPFMT_LONG_BITS) begin
      // too large for any integer size
      f2i_fail = 1'b1;
    end else begin
      f2i_shift = `FPFMT_SIG_WIDTH - up_exp[6:0];
      f2i_mag = up_sig >> f2i_shift;
      f2i_fail = (f2i_mag > f2i_limit) || ((f2i_mag == f2i_limit) && !up_sign);
    end
    if (f2i_fail) begin
      // failed conversion delivers zero
      f2i_value = 32'h00000000;
    end else if (up_sign) begin
      f2i_value = 32'h00000000 - f2i_mag[31:0];
    end else begin
      f2i_value = f2i_mag[31:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // direct pack of the arithmetic result

  // the same pack function serves the integer conversion
  wire [65:0] pk_packed; // packed arithmetic result with flags

  assign pk_packed = fpfmt_pack(pack_sign, pack_exp, pack_significand, double_mode,
    overflow_interrupt_enable, underflow_interrupt_enable);

  // minus zero fetched for a checked operation with the enable set
  // dirty zeros with a clear sign never trap
  wire undef_hit; // trap request before execution

  assign undef_hit = up_undef && check_undefined && undefined_operand_interrupt_enable;

  ////////////////////////////////////////////////////////////////////////////
  // result registers

  // one-cycle operation, results held until the next start
  // reset wins over the clock enable; enable low freezes every register
  // done falls on the next enabled edge without a start
  always @(posedge clock) begin
    if (!nrst) begin
      done <= 1'b0;
      result_word <= `FPFMT_RESET_WORD;
      result_sign <= 1'b0;
      result_exp <= 10'h000;
      result_significand <= 56'h0;
      result_integer <= 32'h00000000;
      flag_zero <= 1'b0;
      flag_dirty_zero <= 1'b0;
      flag_undefined <= 1'b0;
      flag_overflow <= 1'b0;
      flag_underflow <= 1'b0;
      flag_convert_fail <= 1'b0;
      undefined_trap <= 1'b0;
      overflow_trap <= 1'b0;
      underflow_trap <= 1'b0;
    end else if (enable) begin
      done <= start;
      if (start) begin
        // clear all flags, then set those of this operation
        flag_zero <= 1'b0;
        flag_dirty_zero <= 1'b0;
        flag_undefined <= 1'b0;
        flag_overflow <= 1'b0;
        flag_underflow <= 1'b0;
        flag_convert_fail <= 1'b0;
        undefined_trap <= 1'b0;
        overflow_trap <= 1'b0;
        underflow_trap <= 1'b0;
        case (op_code)
          `FPFMT_OP_UNPACK: begin
            // memory operand to sign, exponent, significand
            result_word <= operand;
            result_sign <= up_sign;
            result_exp <= up_exp;
            result_significand <= up_sig;
            result_integer <= 32'h00000000;
            flag_zero <= up_zero;
            flag_dirty_zero <= up_dirty;
            flag_undefined <= up_undef;
            undefined_trap <= undef_hit;
          end
          `FPFMT_OP_PACK: begin
            // arithmetic result to memory form
            result_word <= pk_packed[63:0];
            result_sign <= pack_sign;
            result_exp <= pack_exp;
            result_significand <= pack_significand;
            result_integer <= 32'h00000000;
            flag_zero <= (pk_packed[63:0] == `FPFMT_RESET_WORD);
            flag_overflow <= pk_packed[65];
            flag_underflow <= pk_packed[64];
            overflow_trap <= pk_packed[65] && overflow_interrupt_enable;
            underflow_trap <= pk_packed[64] && underflow_interrupt_enable;
          end
          `FPFMT_OP_I2F: begin
            // integer to packed floating value
            result_word <= i2f_packed[63:0];
            result_sign <= i2f_value[31];
            result_exp <= i2f_exp;
            result_significand <= i2f_sig;
            result_integer <= i2f_value;
            flag_zero <= (i2f_mag == 32'h00000000);
          end
          default: begin
            // packed floating value to integer
            result_word <= operand;
            result_sign <= up_sign;
            result_exp <= up_exp;
            result_significand <= up_sig;
            result_integer <= f2i_value;
            flag_zero <= (f2i_value == 32'h00000000);
            flag_dirty_zero <= up_dirty;
            flag_undefined <= up_undef;
            flag_convert_fail <= f2i_fail;
            undefined_trap <= undef_hit;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// File: test/fpfmt_opmem.sv
// operand memory model feeding packed operands to the format unit
`timescale 1ns/10ps
`default_nettype none
module fpfmt_opmem (
  input wire logic [2:0] sel,
  output logic [63:0] operand
);
  ////////////////////////////////////////////////////////////////////////////////
  // four 16-bit words per operand, first word lands in 63:48
  always_comb begin
    case (sel)
      3'h0: operand = {16'hC0C0, 16'h0000, 16'h0000, 16'h0001}; // negative, true exp 1
      3'h1: operand = {16'h0001, 16'h2345, 32'h0}; // dirty zero
      3'h2: operand = {16'h8000, 48'h0}; // undefined variable
      3'h3: operand = {16'h4100, 48'h0}; // two
      3'h4: operand = {16'h5000, 48'h0}; // two to the 31
      3'h5: operand = {16'h4800, 48'h0}; // two to the 15
      default: operand = 64'h5A5A5A5A5A5A5A5A; // unused slot, no stale data
    endcase
  end
endmodule
`default_nettype wire

// File: test/fpfmt_monitor.sv
// assertion checker bound to the floating operand format unit
`timescale 1ns/10ps
`default_nettype none
`include "fpfmt_consts.vh"
module fpfmt_monitor (
  input wire logic clock,
  input wire logic nrst,
  input wire logic enable,
  input wire logic start,
  input wire logic [1:0] op_code,
  input wire logic double_mode,
  input wire logic check_undefined,
  input wire logic undefined_operand_interrupt_enable,
  input wire logic overflow_interrupt_enable,
  input wire logic underflow_interrupt_enable,
  input wire logic [63:0] operand,
  input wire logic pack_sign,
  input wire logic [9:0] pack_exp,
  input wire logic [55:0] pack_significand,
  input wire logic done,
  input wire logic [63:0] result_word,
  input wire logic result_sign,
  input wire logic [9:0] result_exp,
  input wire logic [55:0] result_significand,
  input wire logic flag_zero,
  input wire logic flag_undefined,
  input wire logic flag_overflow,
  input wire logic overflow_trap,
  input wire logic underflow_trap,
  input wire logic undefined_trap
);
  default clocking mon_ck @(posedge clock); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  // accepted requests by kind
  wire acc = start && enable;
  wire unp = acc && op_code == `FPFMT_OP_UNPACK;
  wire pk = acc && op_code == `FPFMT_OP_PACK && pack_significand[55];
  wire ez = operand[62:55] == 8'h00; // biased exponent zero
  wire hi = $signed(pack_exp) > $signed(`FPFMT_EXP_MAX);
  wire lo = $signed(pack_exp) < $signed(`FPFMT_EXP_MIN);
  ////////////////////////////////////////////////////////////////////////////////
  done_pulse_a: assert property (acc |=> done)
    else $error("done missing after start");
  done_drop_a: assert property (done && enable && !start |=> !done)
    else $error("done held too long");
  unpack_fields_a: assert property (unp && !ez |=> result_sign == $past(operand[63])
    && result_exp == {2'h0, $past(operand[62:55])} - `FPFMT_EXP_BIAS) else $error("unpack field");
  hidden_bit_a: assert property (unp && !ez && double_mode
    |=> result_significand == {1'h1, $past(operand[54:0])}) else $error("hidden bit");
  zero_class_a: assert property (unp && ez |=> flag_zero && result_significand == 56'h0)
    else $error("zero exponent not exact zero");
  undef_class_a: assert property (unp && ez && operand[63] |=> flag_undefined)
    else $error("undefined not classified");
  undef_trap_a: assert property (unp && ez && operand[63] && check_undefined
    |=> undefined_trap == $past(undefined_operand_interrupt_enable)) else $error("undef trap");
  pack_layout_a: assert property (pk && double_mode && !hi && !lo |=> result_word ==
    {$past(pack_sign), $past(pack_exp[7:0]) + 8'h80, $past(pack_significand[54:0])})
    else $error("packed layout");
  ovf_zero_a: assert property (pk && hi && !overflow_interrupt_enable
    |=> flag_overflow && !overflow_trap && result_word == 64'h0) else $error("overflow store");
  unf_trap_a: assert property (pk && double_mode && lo && underflow_interrupt_enable
    |=> underflow_trap && result_word[54:0] == $past(pack_significand[54:0]))
    else $error("underflow fraction");
  single_low_a: assert property (pk && !double_mode |=> result_word[31:0] == 32'h0)
    else $error("single low half");
  // main scenarios
  cover property (unp && ez && operand[63] && check_undefined);
  cover property (pk && hi && !overflow_interrupt_enable);
  cover property (acc && op_code == `FPFMT_OP_F2I);
endmodule
bind fpfmt_unit fpfmt_monitor fpfmt_mon (.clock, .nrst, .enable, .start, .op_code,
  .double_mode, .check_undefined, .undefined_operand_interrupt_enable,
  .overflow_interrupt_enable, .underflow_interrupt_enable, .operand, .pack_sign, .pack_exp,
  .pack_significand, .done, .result_word, .result_sign, .result_exp, .result_significand,
  .flag_zero, .flag_undefined, .flag_overflow, .overflow_trap, .underflow_trap,
  .undefined_trap);
`default_nettype wire

// File: test/tb_top.sv
// self-checking bench for the floating operand format unit
`timescale 1ns/10ps
`default_nettype none
`include "fpfmt_consts.vh"
module tb_top;
  logic clock, nrst, enable, start, double_mode, long_mode, check_undefined, pack_sign;
  logic undefined_operand_interrupt_enable, overflow_interrupt_enable;
  logic underflow_interrupt_enable;
  logic [1:0] op_code;
  logic [2:0] sel; // operand memory slot
  logic [9:0] pack_exp;
  logic [55:0] pack_significand;
  logic [31:0] int_operand;
  wire [63:0] operand, result_word;
  wire [55:0] result_significand;
  wire [9:0] result_exp;
  wire [31:0] result_integer;
  wire done, result_sign, flag_zero, flag_dirty_zero, flag_undefined, flag_overflow;
  wire flag_underflow, flag_convert_fail, undefined_trap, overflow_trap, underflow_trap;
  int n_fail = 0;
  int n_checks = 0;
  fpfmt_opmem mem (.sel, .operand);
  fpfmt_unit dut (.clock, .nrst, .enable, .start, .op_code, .double_mode, .long_mode,
    .check_undefined, .undefined_operand_interrupt_enable, .overflow_interrupt_enable,
    .underflow_interrupt_enable, .operand, .pack_sign, .pack_exp, .pack_significand,
    .int_operand, .done, .result_word, .result_sign, .result_exp, .result_significand,
    .result_integer, .flag_zero, .flag_dirty_zero, .flag_undefined, .flag_overflow,
    .flag_underflow, .flag_convert_fail, .undefined_trap, .overflow_trap, .underflow_trap);
  ////////////////////////////////////////////////////////////////////////////////
  // 10 MHz clock
  initial begin
    clock = 0;
    forever #50 clock = ~clock;
  end
  // verdict and end of run
  task summarize;
    if (n_fail == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // compare one value
  task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  // one request, answer due one cycle later
  task go(input logic [1:0] op);
    op_code = op;
    @(posedge clock);
    #1 start = 1;
    @(posedge clock);
    #1 start = 0;
    chk("done", 1, done);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_unpack;
    sel = 3'h0;
    go(`FPFMT_OP_UNPACK);
    chk("sign", 1, result_sign);
    chk("exp", 1, result_exp);
    chk("sig", 56'hC0000000000001, result_significand);
    double_mode = 0;
    go(`FPFMT_OP_UNPACK);
    chk("ssig", 56'hC0000000000000, result_significand);
    double_mode = 1;
  endtask
  task t_zero;
    sel = 3'h1;
    go(`FPFMT_OP_UNPACK);
    chk("zero", 1, flag_zero);
    chk("dirty", 1, flag_dirty_zero);
    chk("zsig", 0, result_significand);
    sel = 3'h2;
    check_undefined = 1;
    for (int i = 0; i < 2; i++) begin
      undefined_operand_interrupt_enable = i[0];
      go(`FPFMT_OP_UNPACK);
      chk("undef", 1, flag_undefined);
      chk("utrap", i, undefined_trap);
    end
  endtask
  task t_pack;
    pack_exp = 10'h003;
    pack_significand = 56'h80000000000001;
    go(`FPFMT_OP_PACK);
    chk("packed", {1'h0, 8'h83, 55'h1}, result_word);
    double_mode = 0;
    go(`FPFMT_OP_PACK);
    chk("single", {1'h0, 8'h83, 55'h0}, result_word);
    double_mode = 1;
    // extreme representable exponents pass unflagged
    for (int i = 0; i < 2; i++) begin
      pack_exp = i[0] ? 10'h381 : 10'h07F;
      go(`FPFMT_OP_PACK);
      chk("edge word", {1'h0, i[0] ? 8'h01 : 8'hFF, 55'h1}, result_word);
      chk("edge flags", 0, {flag_overflow, flag_underflow});
    end
    // plus and minus 128, interrupts off then on
    for (int i = 0; i < 4; i++) begin
      pack_exp = i[1] ? 10'h380 : 10'h080;
      overflow_interrupt_enable = i[0];
      underflow_interrupt_enable = i[0];
      go(`FPFMT_OP_PACK);
      chk("ovf", !i[1], flag_overflow);
      chk("unf", i[1], flag_underflow);
      chk("trap", i[0], i[1] ? underflow_trap : overflow_trap);
      chk("oword", i[0] ? 64'h1 : 64'h0, result_word);
    end
    pack_significand = 56'h0;
    go(`FPFMT_OP_PACK);
    chk("clean", 0, result_word);
  endtask
  task t_conv;
    int_operand = 32'h0000FFFF;
    go(`FPFMT_OP_I2F);
    chk("i2f", 64'hC080000000000000, result_word);
    sel = 3'h3;
    go(`FPFMT_OP_F2I);
    chk("f2i", 2, result_integer);
    for (int i = 0; i < 2; i++) begin
      long_mode = i[0];
      sel = i[0] ? 3'h4 : 3'h5;
      go(`FPFMT_OP_F2I);
      chk("cfail", 1, flag_convert_fail);
      chk("cint", 0, result_integer);
    end
    sel = 3'h5;
    go(`FPFMT_OP_F2I);
    chk("long", 32'h00008000, result_integer);
  endtask
  // start with the clock enable low is ignored; done and the result word hold
  task t_freeze;
    logic [63:0] held;
    held = result_word;
    enable = 0;
    op_code = `FPFMT_OP_I2F;
    int_operand = 32'h00000005;
    @(posedge clock);
    #1 start = 1;
    @(posedge clock);
    #1 start = 0;
    chk("frozen done", 1, done);
    chk("frozen word", held, result_word);
    enable = 1;
    @(posedge clock);
    #1 chk("late done", 0, done);
    chk("late word", held, result_word);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {nrst, enable, start, long_mode, check_undefined, pack_sign} = 0;
    {undefined_operand_interrupt_enable, overflow_interrupt_enable} = 0;
    underflow_interrupt_enable = 0;
    double_mode = 1;
    {op_code, sel, pack_exp, pack_significand, int_operand} = 0;
    repeat (20) @(posedge clock);
    #1 nrst = 1;
    enable = 1;
    chk("reset word", 0, result_word);
    t_unpack;
    t_zero;
    t_pack;
    t_conv;
    t_freeze;
    summarize();
  end
endmodule
`default_nettype wire
